/* File: rtl/exec_pkg.sv */
// Constants for the instruction decode and flag evaluation block
package exec_pkg;
  // ==========================================================
  // Control register addresses in the register file
  localparam logic [7:0] OFS_IMASK = 8'hfb;
  localparam logic [7:0] OFS_FLAGS = 8'hfc;
  localparam logic [7:0] OFS_WGRP = 8'hfd;
  localparam logic [7:0] OFS_STACK = 8'hff;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_IMASK = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_WGRP = 8'h00;
  localparam logic [7:0] RST_STACK = 8'h00;
  // ==========================================================
  // Flag bit positions
  localparam int FL_C = 7;
  localparam int FL_Z = 6;
  localparam int FL_S = 5;
  localparam int FL_V = 4;
  localparam int FL_D = 3;
  localparam int FL_H = 2;
  localparam int IM_GLOBAL = 7;
  // ==========================================================
  // Condition codes
  localparam logic [3:0] CC_NEVER = 4'h0;
  localparam logic [3:0] CC_SIGNED_BELOW = 4'h1;
  localparam logic [3:0] CC_SIGNED_AT_MOST = 4'h2;
  localparam logic [3:0] CC_UNSIGNED_AT_MOST = 4'h3;
  localparam logic [3:0] CC_OVERFLOWED = 4'h4;
  localparam logic [3:0] CC_NEGATIVE = 4'h5;
  localparam logic [3:0] CC_ZERO = 4'h6;
  localparam logic [3:0] CC_CARRY = 4'h7;
  localparam logic [3:0] CC_ALWAYS = 4'h8;
  localparam logic [3:0] CC_SIGNED_AT_LEAST = 4'h9;
  localparam logic [3:0] CC_SIGNED_ABOVE = 4'ha;
  localparam logic [3:0] CC_UNSIGNED_ABOVE = 4'hb;
  localparam logic [3:0] CC_NOT_OVERFLOWED = 4'hc;
  localparam logic [3:0] CC_POSITIVE = 4'hd;
  localparam logic [3:0] CC_NONZERO = 4'he;
  localparam logic [3:0] CC_NO_CARRY = 4'hf;
  // ==========================================================
  // Opcodes: upper nibbles of the two-operand group
  localparam logic [3:0] GRP_ADD = 4'h0;
  localparam logic [3:0] GRP_ADC = 4'h1;
  localparam logic [3:0] GRP_AND = 4'h5;
  localparam logic [3:0] GRP_CMP = 4'ha;
  localparam logic [3:0] LO_GRP_FIRST = 4'h2;
  localparam logic [3:0] LO_GRP_LAST = 4'h7;
  // Lower nibbles of register-numbered and condition-coded forms
  localparam logic [3:0] LO_LOOP_BRANCH = 4'ha;
  localparam logic [3:0] LO_REL_JUMP = 4'hb;
  localparam logic [3:0] LO_ABS_JUMP = 4'hd;
  localparam logic [3:0] LO_REG_INC = 4'he;
  // Single-operand opcodes
  localparam logic [7:0] OP_DEC_R = 8'h00;
  localparam logic [7:0] OP_DEC_IR = 8'h01;
  localparam logic [7:0] OP_INC_R = 8'h20;
  localparam logic [7:0] OP_INC_IR = 8'h21;
  localparam logic [7:0] OP_JUMP_PAIR = 8'h30;
  localparam logic [7:0] OP_BCD_R = 8'h40;
  localparam logic [7:0] OP_BCD_IR = 8'h41;
  localparam logic [7:0] OP_INV_R = 8'h60;
  localparam logic [7:0] OP_INV_IR = 8'h61;
  localparam logic [7:0] OP_WDEC_RR = 8'h80;
  localparam logic [7:0] OP_WDEC_IR = 8'h81;
  localparam logic [7:0] OP_IDIS = 8'h8f;
  localparam logic [7:0] OP_IEN = 8'h9f;
  localparam logic [7:0] OP_WINC_RR = 8'ha0;
  localparam logic [7:0] OP_WINC_IR = 8'ha1;
  localparam logic [7:0] OP_ZERO_R = 8'hb0;
  localparam logic [7:0] OP_ZERO_IR = 8'hb1;
  localparam logic [7:0] OP_INTERRUPT_RETURN_OP = 8'hbf;
  localparam logic [7:0] OP_PMLOAD = 8'hc2;
  localparam logic [7:0] OP_PMLOAD_INC = 8'hc3;
  localparam logic [7:0] OP_CALL_PAIR = 8'hd4;
  localparam logic [7:0] OP_CALL_DIRECT = 8'hd6;
  localparam logic [7:0] OP_INV_CARRY = 8'hef;
  localparam logic [7:0] OP_NOP = 8'hff;
  // ==========================================================
  // Stack adjustments
  localparam logic [7:0] CALL_STACK_DROP = 8'h02;
  localparam logic [7:0] INTERRUPT_RETURN_OP_FLAGS_POP = 8'h01;
  localparam logic [7:0] INTERRUPT_RETURN_OP_PC_POP = 8'h02;
endpackage

/* File: rtl/cond_eval.sv */
// Condition code evaluator against the flag byte
`timescale 1ns/100ps
module cond_eval (
  input wire logic [3:0] code,
  input wire logic [7:0] flags,
  output logic hit
);
  logic c;
  logic z;
  logic s;
  logic v;
  assign c = flags[exec_pkg::FL_C];
  assign z = flags[exec_pkg::FL_Z];
  assign s = flags[exec_pkg::FL_S];
  assign v = flags[exec_pkg::FL_V];

  // ==========================================================
  // Decode
  always_comb begin
    case (code)
      exec_pkg::CC_ALWAYS: hit = 1'b1;
      exec_pkg::CC_NEVER: hit = 1'b0;
      exec_pkg::CC_CARRY: hit = c;
      exec_pkg::CC_NO_CARRY: hit = !c;
      exec_pkg::CC_ZERO: hit = z;
      exec_pkg::CC_NONZERO: hit = !z;
      exec_pkg::CC_NEGATIVE: hit = s;
      exec_pkg::CC_POSITIVE: hit = !s;
      exec_pkg::CC_OVERFLOWED: hit = v;
      exec_pkg::CC_NOT_OVERFLOWED: hit = !v;
      exec_pkg::CC_SIGNED_AT_LEAST: hit = !(s ^ v);
      exec_pkg::CC_SIGNED_BELOW: hit = s ^ v;
      exec_pkg::CC_SIGNED_ABOVE: hit = !(z | (s ^ v));
      exec_pkg::CC_SIGNED_AT_MOST: hit = z | (s ^ v);
      exec_pkg::CC_UNSIGNED_AT_MOST: hit = c | z;
      exec_pkg::CC_UNSIGNED_ABOVE: hit = !c & !z;
      default: hit = 1'b0;
    endcase
  end
endmodule // cond_eval

/* File: rtl/instr_decode_flag_eval.sv */
// Instruction decode, execute and flag evaluation for an 8-bit core
// Behaviour
// - Flags register holds carry zero sign overflow decimal half
// - Codes 8/0 always/never; 7/F carry set/clear
// - Codes 6/E zero, 5/D sign, 4/C overflow
// - Signed codes 9/1 and A/2 from S,V,Z
// - Code 3 carry-or-zero; B both clear
// - Add with and without carry, update CZSV
// - AND updates Z,S, clears V, keeps C
// - Call drops stack by two, pushes PC, jumps
// - Carry complement inverts carry only
// - Clear writes zero, flags untouched
// - Complement inverts destination, updates Z,S, clears V
// - Compare subtracts, sets CZSV, writes nothing
// - Decimal adjust corrects BCD using H and D
// - Byte and word decrement update Z,S,V
// - Interrupt disable/enable clear/set mask bit 7
// - Loop branch decrements register, branches if nonzero
// - Byte and word increment update Z,S,V, keep C
// - Interrupt return pops flags, PC, sets mask bit
// - Absolute jump on condition; pair form unconditional
// - Relative jump adds signed byte on condition
// - Program memory load moves byte, flags untouched
`timescale 1ns/100ps
module instr_decode_flag_eval #(
  parameter int PC_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic exec_valid,
  input wire logic [7:0] exec_op,
  input wire logic [15:0] exec_dst,
  input wire logic [7:0] exec_src,
  input wire logic [PC_W-1:0] exec_next_pc,
  input wire logic [PC_W-1:0] exec_target,
  input wire logic [7:0] exec_disp,
  input wire logic [7:0] exec_pop_flags,
  input wire logic [PC_W-1:0] exec_pop_pc,
  output logic res_valid,
  output logic res_wr,
  output logic res_word,
  output logic [15:0] res_data,
  output logic res_wreg_sel,
  output logic [7:0] res_wreg,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic push_valid,
  output logic [7:0] push_addr,
  output logic [PC_W-1:0] push_data,
  output logic ptr_inc,
  output logic undef_op,
  output logic [7:0] stack_top,
  output logic [7:0] flags_out,
  output logic [7:0] imask_out,
  output logic [7:0] wgrp_out
);
  // ==========================================================
  // Elaboration check
  if (PC_W < 9 || PC_W > 16) begin : g_bad_pc_w
    $error("PC_W must lie between 9 and 16");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] imask;
    logic [7:0] flags;
    logic [7:0] wgrp;
    logic [7:0] stack;
    logic [7:0] rdata;
    logic res_valid;
    logic res_wr;
    logic res_word;
    logic [15:0] res_data;
    logic res_wreg_sel;
    logic [7:0] res_wreg;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic push_valid;
    logic [7:0] push_addr;
    logic [PC_W-1:0] push_data;
    logic ptr_inc;
    logic undef_op;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] read_mux(input state_t s, input logic [7:0] a);
    case (a)
      exec_pkg::OFS_IMASK: read_mux = s.imask;
      exec_pkg::OFS_FLAGS: read_mux = s.flags;
      exec_pkg::OFS_WGRP: read_mux = s.wgrp;
      exec_pkg::OFS_STACK: read_mux = s.stack;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Zero and sign for an 8-bit result
  function automatic logic [7:0] zs(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] t;
    t = f;
    t[exec_pkg::FL_Z] = (r == 8'h00);
    t[exec_pkg::FL_S] = r[7];
    zs = t;
  endfunction

  function automatic logic [PC_W-1:0] rel(input logic [PC_W-1:0] pc, input logic [7:0] d);
    rel = pc + {{(PC_W-8){d[7]}}, d};
  endfunction

  // ==========================================================
  // Condition evaluation on the upper opcode nibble
  logic cc_hit;
  cond_eval u_cond (
    .code(exec_op[7:4]),
    .flags(st_r.flags),
    .hit(cc_hit)
  );

  // ==========================================================
  // Datapath terms
  logic [3:0] op_hi;
  logic [3:0] op_lo;
  logic [7:0] a;
  logic [7:0] b;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic [8:0] dif9;
  logic [7:0] bcd;
  logic bcd_c;
  logic [7:0] dec8;
  logic [7:0] inc8;
  logic [15:0] dec16;
  logic [15:0] inc16;
  logic cin;

  always_comb begin
    op_hi = exec_op[7:4];
    op_lo = exec_op[3:0];
    a = exec_dst[7:0];
    b = exec_src;
    cin = (op_hi == exec_pkg::GRP_ADC) ? st_r.flags[exec_pkg::FL_C] : 1'b0;
    sum9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    half5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    dif9 = {1'b0, a} - {1'b0, b};
    dec8 = a - 8'h01;
    inc8 = a + 8'h01;
    dec16 = exec_dst - 16'h0001;
    inc16 = exec_dst + 16'h0001;
    // Decimal correction depends on the D flag: add path when D is clear, subtract path when D is set
    bcd = a;
    bcd_c = st_r.flags[exec_pkg::FL_C];
    if (!st_r.flags[exec_pkg::FL_D]) begin
      if (st_r.flags[exec_pkg::FL_C] || a > 8'h99) begin
        bcd = bcd + 8'h60;
        bcd_c = 1'b1;
      end
      if (st_r.flags[exec_pkg::FL_H] || a[3:0] > 4'h9) begin
        bcd = bcd + 8'h06;
      end
    end else begin
      if (st_r.flags[exec_pkg::FL_C]) begin
        bcd = bcd - 8'h60;
      end
      if (st_r.flags[exec_pkg::FL_H]) begin
        bcd = bcd - 8'h06;
      end
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    st_nxt.res_valid = 1'b0;
    st_nxt.res_wr = 1'b0;
    st_nxt.res_word = 1'b0;
    st_nxt.res_wreg_sel = 1'b0;
    st_nxt.pc_load = 1'b0;
    st_nxt.push_valid = 1'b0;
    st_nxt.ptr_inc = 1'b0;
    st_nxt.undef_op = 1'b0;
    if (reg_rd) begin
      st_nxt.rdata = read_mux(st_r, reg_addr);
    end
    // Software write first, so an executing instruction in the same cycle wins
    if (reg_wr) begin
      case (reg_addr)
        exec_pkg::OFS_IMASK: st_nxt.imask = reg_wdata;
        exec_pkg::OFS_FLAGS: st_nxt.flags = reg_wdata;
        exec_pkg::OFS_WGRP: st_nxt.wgrp = reg_wdata;
        exec_pkg::OFS_STACK: st_nxt.stack = reg_wdata;
        default: st_nxt.stack = st_nxt.stack;
      endcase
    end
    if (exec_valid) begin
      st_nxt.res_valid = 1'b1;
      case (exec_op)
        exec_pkg::OP_INV_CARRY: begin
          st_nxt.flags[exec_pkg::FL_C] = !st_r.flags[exec_pkg::FL_C];
        end
        exec_pkg::OP_ZERO_R, exec_pkg::OP_ZERO_IR: begin
          st_nxt.res_wr = 1'b1;
          st_nxt.res_data = 16'h0000;
        end
        exec_pkg::OP_INV_R, exec_pkg::OP_INV_IR: begin
          st_nxt.res_wr = 1'b1;
          st_nxt.res_data = {8'h00, ~a};
          st_nxt.flags = zs(st_r.flags, ~a);
          st_nxt.flags[exec_pkg::FL_V] = 1'b0;
        end
        exec_pkg::OP_BCD_R, exec_pkg::OP_BCD_IR: begin
          st_nxt.res_wr = 1'b1;
          st_nxt.res_data = {8'h00, bcd};
          st_nxt.flags = zs(st_r.flags, bcd);
          st_nxt.flags[exec_pkg::FL_C] = bcd_c;
        end
        exec_pkg::OP_DEC_R, exec_pkg::OP_DEC_IR: begin
          st_nxt.res_wr = 1'b1;
          st_nxt.res_data = {8'h00, dec8};
          st_nxt.flags = zs(st_r.flags, dec8);
          st_nxt.flags[exec_pkg::FL_V] = (a == 8'h80);
        end
        exec_pkg::OP_INC_R, exec_pkg::OP_INC_IR: begin
          st_nxt.res_wr = 1'b1;
          st_nxt.res_data = {8'h00, inc8};
          st_nxt.flags = zs(st_r.flags, inc8);
          st_nxt.flags[exec_pkg::FL_V] = (a == 8'h7f);
        end
        exec_pkg::OP_WDEC_RR, exec_pkg::OP_WDEC_IR: begin
          st_nxt.res_wr = 1'b1;
          st_nxt.res_word = 1'b1;
          st_nxt.res_data = dec16;
          st_nxt.flags[exec_pkg::FL_Z] = (dec16 == 16'h0000);
          st_nxt.flags[exec_pkg::FL_S] = dec16[15];
          st_nxt.flags[exec_pkg::FL_V] = (exec_dst == 16'h8000);
        end
        exec_pkg::OP_WINC_RR, exec_pkg::OP_WINC_IR: begin
          st_nxt.res_wr = 1'b1;
          st_nxt.res_word = 1'b1;
          st_nxt.res_data = inc16;
          st_nxt.flags[exec_pkg::FL_Z] = (inc16 == 16'h0000);
          st_nxt.flags[exec_pkg::FL_S] = inc16[15];
          st_nxt.flags[exec_pkg::FL_V] = (exec_dst == 16'h7fff);
        end
        exec_pkg::OP_IDIS: st_nxt.imask[exec_pkg::IM_GLOBAL] = 1'b0;
        exec_pkg::OP_IEN: st_nxt.imask[exec_pkg::IM_GLOBAL] = 1'b1;
        exec_pkg::OP_INTERRUPT_RETURN_OP: begin
          // Both pops are folded into one step: flags byte then the return address
          st_nxt.flags = exec_pop_flags;
          st_nxt.stack = st_r.stack + exec_pkg::INTERRUPT_RETURN_OP_FLAGS_POP + exec_pkg::INTERRUPT_RETURN_OP_PC_POP;
          st_nxt.pc_load = 1'b1;
          st_nxt.pc_value = exec_pop_pc;
          st_nxt.imask[exec_pkg::IM_GLOBAL] = 1'b1;
        end
        exec_pkg::OP_JUMP_PAIR: begin
          st_nxt.pc_load = 1'b1;
          st_nxt.pc_value = exec_target;
        end
        exec_pkg::OP_CALL_DIRECT, exec_pkg::OP_CALL_PAIR: begin
          st_nxt.stack = st_r.stack - exec_pkg::CALL_STACK_DROP;
          st_nxt.push_valid = 1'b1;
          st_nxt.push_addr = st_r.stack - exec_pkg::CALL_STACK_DROP;
          st_nxt.push_data = exec_next_pc;
          st_nxt.pc_load = 1'b1;
          st_nxt.pc_value = exec_target;
        end
        exec_pkg::OP_PMLOAD, exec_pkg::OP_PMLOAD_INC: begin
          st_nxt.res_wr = 1'b1;
          st_nxt.res_data = {8'h00, b};
          st_nxt.ptr_inc = (exec_op == exec_pkg::OP_PMLOAD_INC);
        end
        exec_pkg::OP_NOP: st_nxt.res_wr = 1'b0;
        default: begin
          if (op_lo >= exec_pkg::LO_GRP_FIRST && op_lo <= exec_pkg::LO_GRP_LAST &&
              (op_hi == exec_pkg::GRP_ADD || op_hi == exec_pkg::GRP_ADC)) begin
            st_nxt.res_wr = 1'b1;
            st_nxt.res_data = {8'h00, sum9[7:0]};
            st_nxt.flags = zs(st_r.flags, sum9[7:0]);
            st_nxt.flags[exec_pkg::FL_C] = sum9[8];
            st_nxt.flags[exec_pkg::FL_V] = (a[7] == b[7]) && (sum9[7] != a[7]);
            st_nxt.flags[exec_pkg::FL_D] = 1'b0;
            st_nxt.flags[exec_pkg::FL_H] = half5[4];
          end else if (op_lo >= exec_pkg::LO_GRP_FIRST && op_lo <= exec_pkg::LO_GRP_LAST &&
                       op_hi == exec_pkg::GRP_AND) begin
            st_nxt.res_wr = 1'b1;
            st_nxt.res_data = {8'h00, a & b};
            st_nxt.flags = zs(st_r.flags, a & b);
            st_nxt.flags[exec_pkg::FL_V] = 1'b0;
          end else if (op_lo >= exec_pkg::LO_GRP_FIRST && op_lo <= exec_pkg::LO_GRP_LAST &&
                       op_hi == exec_pkg::GRP_CMP) begin
            st_nxt.flags = zs(st_r.flags, dif9[7:0]);
            st_nxt.flags[exec_pkg::FL_C] = dif9[8];
            st_nxt.flags[exec_pkg::FL_V] = (a[7] != b[7]) && (dif9[7] != a[7]);
          end else if (op_lo == exec_pkg::LO_LOOP_BRANCH) begin
            // Working register number is the upper opcode nibble
            st_nxt.res_wr = 1'b1;
            st_nxt.res_wreg_sel = 1'b1;
            st_nxt.res_wreg = {st_r.wgrp[7:4], op_hi};
            st_nxt.res_data = {8'h00, dec8};
            st_nxt.pc_load = (dec8 != 8'h00);
            st_nxt.pc_value = rel(exec_next_pc, exec_disp);
          end else if (op_lo == exec_pkg::LO_REL_JUMP) begin
            st_nxt.pc_load = cc_hit;
            st_nxt.pc_value = rel(exec_next_pc, exec_disp);
          end else if (op_lo == exec_pkg::LO_ABS_JUMP) begin
            st_nxt.pc_load = cc_hit;
            st_nxt.pc_value = exec_target;
          end else if (op_lo == exec_pkg::LO_REG_INC) begin
            st_nxt.res_wr = 1'b1;
            st_nxt.res_wreg_sel = 1'b1;
            st_nxt.res_wreg = {st_r.wgrp[7:4], op_hi};
            st_nxt.res_data = {8'h00, inc8};
            st_nxt.flags = zs(st_r.flags, inc8);
            st_nxt.flags[exec_pkg::FL_V] = (a == 8'h7f);
          end else begin
            // Blank or out-of-scope opcode: flags, stack and mask keep their registered values, dropping a same-cycle software write
            st_nxt.undef_op = 1'b1;
            st_nxt.flags = st_r.flags;
            st_nxt.stack = st_r.stack;
            st_nxt.imask = st_r.imask;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.imask <= exec_pkg::RST_IMASK;
      st_r.flags <= exec_pkg::RST_FLAGS;
      st_r.wgrp <= exec_pkg::RST_WGRP;
      st_r.stack <= exec_pkg::RST_STACK;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = st_r.rdata;
  assign res_valid = st_r.res_valid;
  assign res_wr = st_r.res_wr;
  assign res_word = st_r.res_word;
  assign res_data = st_r.res_data;
  assign res_wreg_sel = st_r.res_wreg_sel;
  assign res_wreg = st_r.res_wreg;
  assign pc_load = st_r.pc_load;
  assign pc_value = st_r.pc_value;
  assign push_valid = st_r.push_valid;
  assign push_addr = st_r.push_addr;
  assign push_data = st_r.push_data;
  assign ptr_inc = st_r.ptr_inc;
  assign undef_op = st_r.undef_op;
  assign stack_top = st_r.stack;
  assign flags_out = st_r.flags;
  assign imask_out = st_r.imask;
  assign wgrp_out = st_r.wgrp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_issue(logic [7:0] op);
    ce && exec_valid && !reg_wr && exec_op == op;
  endsequence

  sequence s_call;
    ce && exec_valid && !reg_wr &&
      (exec_op == exec_pkg::OP_CALL_DIRECT || exec_op == exec_pkg::OP_CALL_PAIR);
  endsequence

  carry_invert_a: assert property (s_issue(exec_pkg::OP_INV_CARRY) |=>
    flags_out == ($past(flags_out) ^ 8'h80)) else $error("carry complement wrong");

  clear_keeps_a: assert property (s_issue(exec_pkg::OP_ZERO_R) |=>
    res_wr && res_data == 16'h0000 && $stable(flags_out)) else $error("clear touched flags");

  call_stack_a: assert property (s_call |=> push_valid && pc_load &&
    stack_top == $past(stack_top) - 8'h02 && push_addr == stack_top)
    else $error("call stack wrong");

  interrupt_return_op_restore_a: assert property (s_issue(exec_pkg::OP_INTERRUPT_RETURN_OP) |=> pc_load &&
    stack_top == $past(stack_top) + 8'h03 && imask_out[7] && flags_out == $past(exec_pop_flags))
    else $error("interrupt return wrong");

  mask_bit_a: assert property (s_issue(exec_pkg::OP_IDIS) ##1 s_issue(exec_pkg::OP_IEN) |->
    !imask_out[7] ##1 imask_out[7] && $stable(flags_out)) else $error("mask bit wrong");

  undef_hold_a: assert property (ce && exec_valid && !reg_wr && exec_op == 8'hd0 |=>
    undef_op && $stable(flags_out) && $stable(stack_top) && $stable(imask_out))
    else $error("blank opcode changed state");

  jump_always_a: assert property (s_issue(8'h8b) |=> pc_load &&
    pc_value == rel($past(exec_next_pc), $past(exec_disp))) else $error("always jump missed");

  jump_never_a: assert property (s_issue(8'h0d) |=> !pc_load) else $error("never jump taken");

  and_flags_a: assert property (ce && exec_valid && !reg_wr && exec_op[7:4] == 4'h5 &&
    exec_op[3:0] == 4'h2 |=> !flags_out[exec_pkg::FL_V] && flags_out[7] == $past(flags_out[7]))
    else $error("and flags wrong");

  loop_branch_a: assert property (ce && exec_valid && !reg_wr && exec_op[3:0] == 4'ha &&
    exec_dst[7:0] == 8'h01 |=> !pc_load && res_data[7:0] == 8'h00) else $error("loop exit wrong");

  read_answer_a: assert property (ce && reg_rd && reg_addr == exec_pkg::OFS_STACK &&
    !exec_valid && !reg_wr |=> reg_rdata == stack_top) else $error("read data wrong");
endmodule // instr_decode_flag_eval

/* File: test/stack_mem_model.sv */
// Stack memory stub standing in for the core's register file
`timescale 1ns/100ps
module stack_mem_model #(
  parameter int PC_W = 16
) (
  input wire logic clk,
  input wire logic push_valid,
  input wire logic [7:0] push_addr,
  input wire logic [PC_W-1:0] push_data,
  input wire logic [7:0] stack_top,
  output logic [7:0] pop_flags,
  output logic [PC_W-1:0] pop_pc
);
  // ==========================================
  // Storage
  // Unwritten cells hold a pattern so a stale zero can pass only from cell 5a
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
  always @(posedge clk) begin
    if (push_valid) begin
      mem[push_addr] <= push_data[15:8];
      mem[8'(push_addr + 8'h01)] <= push_data[7:0];
    end
  end
  assign pop_flags = mem[stack_top];
  assign pop_pc = PC_W'({mem[8'(stack_top + 8'h01)], mem[8'(stack_top + 8'h02)]});
endmodule // stack_mem_model

/* File: test/instr_decode_flag_eval_tb.sv */
// Self-checking bench for the decode and flag block
`timescale 1ns/100ps
module instr_decode_flag_eval_tb;
  // ==========================================
  // Signals
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, exec_valid = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, exec_op = 8'h00, exec_src = 8'h00;
  logic [7:0] exec_disp = 8'h00, fl = 8'h00, reg_rdata, flags_out, stack_top, push_addr, pop_flags;
  logic [15:0] exec_dst = 16'h0000, exec_target = 16'h0000, rpc = 16'h4c21;
  logic [15:0] res_data, push_data, pop_pc;
  logic res_valid, pc_load, push_valid;
  logic [31:0] rs = 32'h3ec9;
  logic [17:0] eq [$];
  logic [17:0] me;
  logic [7:0] rq [$];
  logic [7:0] ops [11] = '{8'h02, 8'h12, 8'h52, 8'ha2, 8'h20, 8'h00, 8'h60, 8'hb0, 8'hef, 8'hc7,
    8'hc2};
  logic [7:0] ra [5] = '{8'hfb, 8'hfc, 8'hfd, 8'hff, 8'hfe};
  int mismatches = 0, tests_run = 0;
  always #5 clk = ~clk;
  always @(posedge clk) rd_d <= reg_rd;
  instr_decode_flag_eval instr_decode_flag_eval_i (.clk(clk), .resetn(resetn), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .exec_valid(exec_valid), .exec_op(exec_op), .exec_dst(exec_dst),
    .exec_src(exec_src), .exec_next_pc(rpc), .exec_target(exec_target), .exec_disp(exec_disp),
    .exec_pop_flags(pop_flags), .exec_pop_pc(pop_pc), .res_valid(res_valid), .res_wr(),
    .res_word(), .res_data(res_data), .res_wreg_sel(), .res_wreg(), .pc_load(pc_load),
    .pc_value(), .push_valid(push_valid), .push_addr(push_addr), .push_data(push_data),
    .ptr_inc(), .undef_op(), .stack_top(stack_top), .flags_out(flags_out), .imask_out(),
    .wgrp_out());
  stack_mem_model stack_mem_model_i (.clk(clk), .push_valid(push_valid), .push_addr(push_addr),
    .push_data(push_data), .stack_top(stack_top), .pop_flags(pop_flags), .pop_pc(pop_pc));
  // ==========================================
  // Reference and helpers
  function automatic logic [7:0] xr();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  function automatic logic cnd(input logic [3:0] c, input logic [7:0] f);
    logic [7:0] t;
    t = {f[7], f[6], f[5], f[4], f[7] | f[6], f[6] | (f[5] ^ f[4]), f[5] ^ f[4], 1'b0};
    return c[3] ^ t[c[2:0]];
  endfunction
  function automatic logic [15:0] ref_op(input logic [7:0] op, a, b, input logic [7:0] f);
    logic [8:0] s;
    logic [7:0] r;
    logic v, h;
    r = (op[3:0] == 4'ha) ? a - 8'h01 : a;
    v = f[4];
    case (op)
      8'h02, 8'h12: begin
        h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, op[4] & f[7]}) > 5'h0f;
        s = {1'b0, a} + {1'b0, b} + {8'h00, op[4] & f[7]};
        r = s[7:0];
        v = (a[7] == b[7]) && (r[7] != a[7]);
        {f[7], f[3], f[2]} = {s[8], 1'b0, h};
      end
      8'ha2: begin
        s = {1'b0, a} - {1'b0, b};
        r = s[7:0];
        v = (a[7] != b[7]) && (r[7] != a[7]);
        f[7] = s[8];
      end
      8'h52: {r, v} = {a & b, 1'b0};
      8'h20: {r, v} = {a + 8'h01, a == 8'h7f};
      8'h00: {r, v} = {a - 8'h01, a == 8'h80};
      8'h60: {r, v} = {~a, 1'b0};
      8'hc2: return {f, b};
      // Add path only: scenarios clear the decimal flag first
      8'h40: begin
        r = a + ((f[7] || a > 8'h99) ? 8'h60 : 8'h00);
        r = r + ((f[2] || a[3:0] > 4'h9) ? 8'h06 : 8'h00);
        f[7] = f[7] || a > 8'h99;
      end
      8'hb0: return {f, 8'h00};
      8'hef: return {f ^ 8'h80, a};
      default: return {f, r};
    endcase
    return {f[7], r == 8'h00, r[7], v, f[3:0], r};
  endfunction
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] y);
    tests_run++;
    if (x !== y) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'hfc) fl = d;
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    exec_valid <= 1'b0;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    exec_valid <= 1'b0;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic ex(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    logic [15:0] e;
    logic j, dv;
    e = ref_op(op, a, b, fl);
    j = (op[3:0] inside {4'hd, 4'hb}) ? cnd(op[7:4], fl) : (op inside {8'hd6, 8'hbf});
    if (op[3:0] == 4'ha) j = (a != 8'h01);
    if (op == 8'hbf) e[15:8] = rpc[15:8];
    dv = (op inside {8'h02, 8'h12, 8'h52, 8'h20, 8'h00, 8'h60, 8'hb0, 8'h40, 8'hc2}) ||
      op[3:0] == 4'ha;
    eq.push_back({dv, j, e});
    fl = e[15:8];
    @(posedge clk);
    {exec_valid, exec_op, exec_dst, exec_src} <= {1'b1, op, 8'h00, a, b};
    {exec_target, exec_disp} <= {xr(), xr(), xr()};
    // Valid stays up so ops can run back to back; the bus tasks drop it
  endtask
  // ==========================================
  // Result watcher
  always @(negedge clk) begin
    if (res_valid === 1'b1 && eq.size() > 0) begin
      me = eq.pop_front();
      chk("flags", me[15:8], flags_out);
      chk("pc_load", {7'h00, me[16]}, {7'h00, pc_load});
      if (me[17]) chk("result", me[7:0], res_data[7:0]);
    end
    if (rd_d === 1'b1 && rq.size() > 0) chk("rdata", rq.pop_front(), reg_rdata);
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(8'hfc, xr());
      ex({4'(i), 4'hd}, 8'h00, 8'h00);
      ex({4'(i), 4'hb}, 8'h00, 8'h00);
    end
    repeat (80) ex(ops[int'(xr()) % 11], xr(), xr());
    ex(8'h3a, 8'h01, 8'h00);
    ex(8'h3a, 8'h05, 8'h00);
    ex(8'hd0, 8'h00, 8'h00);
    wr(8'hfc, 8'h00);
    ex(8'h40, 8'h9a, 8'h00);
    wr(8'hff, 8'h40);
    ex(8'h9f, 8'h00, 8'h00);
    rd(8'hfb, 8'h80);
    ex(8'h8f, 8'h00, 8'h00);
    rd(8'hfb, 8'h00);
    ex(8'h8f, 8'h00, 8'h00);
    ex(8'h9f, 8'h00, 8'h00);
    ex(8'hd6, 8'h00, 8'h00);
    rd(8'hff, 8'h3e);
    ex(8'hbf, 8'h00, 8'h00);
    rd(8'hff, 8'h41);
    rd(8'hfb, 8'h80);
    rd(8'hfc, fl);
    for (int i = 0; i < 20 && (eq.size() > 0 || rq.size() > 0); i++) @(posedge clk);
    if (eq.size() > 0 || rq.size() > 0) mismatches++;
    stop_test();
  end
endmodule // instr_decode_flag_eval_tb
